/* verilog/capture_compare_unit.v */
// capture/compare unit for one channel of a 16-bit timer
//
// Behaviour
// - control bits 15:14 pick the capture B edge: none, rising, falling or both, reset none.
// - control bits 7:6 pick the capture A edge with the same coding, reset none.
// - control bits 13:12 set wave B: off, high on match A and low on match B, toggle on A, toggle on B.
// - control bits 5:4 set wave A with the same four modes.
// - bit 9 inverts wave B and bit 1 inverts wave A, both reset to normal.
// - bit 8 makes data register B a capture register when 1, a comparator when 0, reset 0.
// - bit 0 makes data register A a capture register when 1, a comparator when 0, reset 0.
// - data register A is 16-bit read/write, reset 0, holding the compare value or the capture.
// - data register B is 16-bit read/write, reset 0, holding the compare value or the capture.
// - six interrupt enable bits 5:0: lost B, lost A, capture B, capture A, match B, match A.
// - all interrupt enables reset to 0.
// - six interrupt flags in the same bit order read 1 once their event has occurred.
// - writing 1 clears a flag, writing 0 leaves it, and all flags reset to 0.

`timescale 1ns/10ps
`default_nettype none

`include "capture_compare_regs.vh"

module capture_compare_unit #(
	parameter WIDTH = 16
) (
	input  wire                  CLK,
	input  wire                  RESET,
	input  wire [`CC_ADDR_W-1:0] ADDR,
	input  wire [15:0]           WDATA,
	input  wire                  WRITE,
	input  wire                  READ,
	output reg  [15:0]           RDATA,
	input  wire [WIDTH-1:0]      COUNT,
	input  wire                  CAPTURE_A_PIN,
	input  wire                  CAPTURE_B_PIN,
	output reg                   WAVE_A,
	output reg                   WAVE_B,
	output reg                   IRQ
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function edge_hit;
	input [1:0] sel;
	input       prev;
	input       now;
	begin
		case (sel)
			`CC_EDGE_RISE: edge_hit = !prev && now;
			`CC_EDGE_FALL: edge_hit = prev && !now;
			`CC_EDGE_BOTH: edge_hit = prev != now;
			default:       edge_hit = 1'b0;
		endcase
	end
endfunction

function wave_next;
	input [1:0] mode;
	input       cur;
	input       hit_a;
	input       hit_b;
	begin
		case (mode)
			`CC_WAVE_SET_CLR: wave_next = hit_a ? 1'b1 : (hit_b ? 1'b0 : cur);
			`CC_WAVE_TOG_A:   wave_next = hit_a ? !cur : cur;
			`CC_WAVE_TOG_B:   wave_next = hit_b ? !cur : cur;
			default:          wave_next = 1'b0;
		endcase
	end
endfunction

// exact decode of a register's byte address, shared by reads and writes
function reg_hit;
	input [`CC_ADDR_W-1:0] addr;
	input [`CC_ADDR_W-1:0] offset;
	begin
		reg_hit = addr == offset;
	end
endfunction

// data registers read back zero-extended to the bus width
function [15:0] pad_data;
	input [WIDTH-1:0] value;
	begin
		pad_data = 16'h0000;
		pad_data[WIDTH-1:0] = value;
	end
endfunction

// reserved interrupt bits read as 0
function [15:0] pad_irq;
	input [`CC_IRQ_W-1:0] value;
	begin
		pad_irq = 16'h0000;
		pad_irq[`CC_IRQ_W-1:0] = value;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [15:0]            control;
reg [WIDTH-1:0]       match_or_snapshot_a;
reg [WIDTH-1:0]       match_or_snapshot_b;
reg [`CC_IRQ_W-1:0]   irq_enable;
reg [`CC_IRQ_W-1:0]   irq_flag;
reg                   wave_a_raw;
reg                   wave_b_raw;

// pins pass three flops; the first is read only by the second
reg [2:0]             sync_a;
reg [2:0]             sync_b;
reg                   level_a;
reg                   level_b;
reg [WIDTH-1:0]       count_prev;

wire [1:0] capture_b_edge_select = control[`CC_CTL_B_EDGE_HI:`CC_CTL_B_EDGE_LO];
wire [1:0] capture_a_edge_select = control[`CC_CTL_A_EDGE_HI:`CC_CTL_A_EDGE_LO];
wire [1:0] wave_b_mode           = control[`CC_CTL_B_MODE_HI:`CC_CTL_B_MODE_LO];
wire [1:0] wave_a_mode           = control[`CC_CTL_A_MODE_HI:`CC_CTL_A_MODE_LO];
wire       wave_b_invert         = control[`CC_CTL_B_INVERT];
wire       wave_a_invert         = control[`CC_CTL_A_INVERT];
wire       reg_b_function_select = control[`CC_CTL_B_FUNC];
wire       reg_a_function_select = control[`CC_CTL_A_FUNC];

wire wr_control = WRITE && reg_hit(ADDR, `CC_OFF_CONTROL);
wire wr_a       = WRITE && reg_hit(ADDR, `CC_OFF_A_DATA);
wire wr_b       = WRITE && reg_hit(ADDR, `CC_OFF_B_DATA);
wire wr_enable  = WRITE && reg_hit(ADDR, `CC_OFF_IRQ_ENABLE);
wire wr_flags   = WRITE && reg_hit(ADDR, `CC_OFF_IRQ_FLAGS);

wire rd_control = READ && reg_hit(ADDR, `CC_OFF_CONTROL);
wire rd_a       = READ && reg_hit(ADDR, `CC_OFF_A_DATA);
wire rd_b       = READ && reg_hit(ADDR, `CC_OFF_B_DATA);
wire rd_enable  = READ && reg_hit(ADDR, `CC_OFF_IRQ_ENABLE);
wire rd_flags   = READ && reg_hit(ADDR, `CC_OFF_IRQ_FLAGS);

////////////////////////////////////////////////////////////////////////////////
// event detection

// a change counts once the second and third flops agree
wire agree_a = sync_a[1] == sync_a[2];
wire agree_b = sync_b[1] == sync_b[2];
wire snap_a  = reg_a_function_select && agree_a &&
	edge_hit(capture_a_edge_select, level_a, sync_a[2]);
wire snap_b  = reg_b_function_select && agree_b &&
	edge_hit(capture_b_edge_select, level_b, sync_b[2]);

// match fires once per new count value, not for every clock it dwells
wire count_moved = COUNT != count_prev;
wire match_a = !reg_a_function_select && count_moved && COUNT == match_or_snapshot_a;
wire match_b = !reg_b_function_select && count_moved && COUNT == match_or_snapshot_b;

reg [`CC_IRQ_W-1:0] events;
always @* begin
	events = {`CC_IRQ_W{1'b0}};
	events[`CC_IRQ_MATCH_A] = match_a;
	events[`CC_IRQ_MATCH_B] = match_b;
	events[`CC_IRQ_SNAP_A]  = snap_a;
	events[`CC_IRQ_SNAP_B]  = snap_b;
	events[`CC_IRQ_LOST_A]  = snap_a && irq_flag[`CC_IRQ_SNAP_A];
	events[`CC_IRQ_LOST_B]  = snap_b && irq_flag[`CC_IRQ_SNAP_B];
end

wire [`CC_IRQ_W-1:0] clear_mask = wr_flags ? WDATA[`CC_IRQ_W-1:0] : {`CC_IRQ_W{1'b0}};
// set beats clear so an event in the clearing cycle is kept
wire [`CC_IRQ_W-1:0] next_flag  = (irq_flag & ~clear_mask) | events;

////////////////////////////////////////////////////////////////////////////////
// next values

reg [15:0]            next_control;
reg [WIDTH-1:0]       next_data_a;
reg [WIDTH-1:0]       next_data_b;
reg [`CC_IRQ_W-1:0]   next_enable;
reg                   next_level_a;
reg                   next_level_b;
reg [15:0]            next_rdata;

always @* begin
	next_control = control;
	if (wr_control)
		next_control = WDATA & `CC_CTL_MASK;
end

// capture outranks a software write in the same cycle
always @* begin
	next_data_a = match_or_snapshot_a;
	if (snap_a)
		next_data_a = COUNT;
	else if (wr_a)
		next_data_a = WDATA[WIDTH-1:0];
end

always @* begin
	next_data_b = match_or_snapshot_b;
	if (snap_b)
		next_data_b = COUNT;
	else if (wr_b)
		next_data_b = WDATA[WIDTH-1:0];
end

always @* begin
	next_enable = irq_enable;
	if (wr_enable)
		next_enable = WDATA[`CC_IRQ_W-1:0];
end

// the level only follows the pin once the second and third flops agree
always @* begin
	next_level_a = level_a;
	if (agree_a)
		next_level_a = sync_a[2];
end

always @* begin
	next_level_b = level_b;
	if (agree_b)
		next_level_b = sync_b[2];
end

// only the addressed register drives the bus; all else reads 0
always @* begin
	next_rdata = 16'h0000;
	if (rd_control)
		next_rdata = control;
	if (rd_a)
		next_rdata = pad_data(match_or_snapshot_a);
	if (rd_b)
		next_rdata = pad_data(match_or_snapshot_b);
	if (rd_enable)
		next_rdata = pad_irq(irq_enable);
	if (rd_flags)
		next_rdata = pad_irq(irq_flag);
end

// both outputs see the same pair of match events, only the mode differs
wire next_wave_a_raw = wave_next(wave_a_mode, wave_a_raw, match_a, match_b);
wire next_wave_b_raw = wave_next(wave_b_mode, wave_b_raw, match_a, match_b);
// invert after the mode logic so a polarity change never disturbs the toggle state
wire next_wave_a     = next_wave_a_raw ^ wave_a_invert;
wire next_wave_b     = next_wave_b_raw ^ wave_b_invert;
// new enables count at once, so a masked flag never raises a request
wire next_irq        = |(next_flag & next_enable);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

always @(posedge CLK) begin
	if (RESET) begin
		sync_a  <= 3'h0;
		level_a <= 1'b0;
	end else begin
		sync_a  <= {sync_a[1:0], CAPTURE_A_PIN};
		level_a <= next_level_a;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		sync_b  <= 3'h0;
		level_b <= 1'b0;
	end else begin
		sync_b  <= {sync_b[1:0], CAPTURE_B_PIN};
		level_b <= next_level_b;
	end
end

// the match strobe is one clock per new count value
always @(posedge CLK) begin
	if (RESET) begin
		count_prev <= {WIDTH{1'b0}};
	end else begin
		count_prev <= COUNT;
	end
end

////////////////////////////////////////////////////////////////////////////////
// software registers

always @(posedge CLK) begin
	if (RESET) begin
		control <= `CC_RESET_VALUE;
	end else begin
		control <= next_control;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		match_or_snapshot_a <= {WIDTH{1'b0}};
	end else begin
		match_or_snapshot_a <= next_data_a;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		match_or_snapshot_b <= {WIDTH{1'b0}};
	end else begin
		match_or_snapshot_b <= next_data_b;
	end
end

// every source starts masked
always @(posedge CLK) begin
	if (RESET) begin
		irq_enable <= {`CC_IRQ_W{1'b0}};
	end else begin
		irq_enable <= next_enable;
	end
end

// flags stay set until software writes 1 to them
always @(posedge CLK) begin
	if (RESET) begin
		irq_flag <= {`CC_IRQ_W{1'b0}};
	end else begin
		irq_flag <= next_flag;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, each straight from its own flop

always @(posedge CLK) begin
	if (RESET) begin
		wave_a_raw <= 1'b0;
	end else begin
		wave_a_raw <= next_wave_a_raw;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		wave_b_raw <= 1'b0;
	end else begin
		wave_b_raw <= next_wave_b_raw;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		WAVE_A <= 1'b0;
	end else begin
		WAVE_A <= next_wave_a;
	end
end

always @(posedge CLK) begin
	if (RESET) begin
		WAVE_B <= 1'b0;
	end else begin
		WAVE_B <= next_wave_b;
	end
end

// one level request for all six sources
always @(posedge CLK) begin
	if (RESET) begin
		IRQ <= 1'b0;
	end else begin
		IRQ <= next_irq;
	end
end

// read data stands for the one cycle after the strobe
always @(posedge CLK) begin
	if (RESET) begin
		RDATA <= 16'h0000;
	end else begin
		RDATA <= next_rdata;
	end
end

endmodule // capture_compare_unit

`default_nettype wire

/* verilog/capture_compare_regs.vh */
// register offsets, field positions and reset values of the capture/compare unit
`ifndef CAPTURE_COMPARE_REGS_VH
`define CAPTURE_COMPARE_REGS_VH

`define CC_ADDR_W           16
`define CC_OFF_CONTROL      16'h5424
`define CC_OFF_A_DATA       16'h5426
`define CC_OFF_B_DATA       16'h5428
`define CC_OFF_IRQ_ENABLE   16'h542a
`define CC_OFF_IRQ_FLAGS    16'h542c

`define CC_CTL_B_EDGE_HI    15
`define CC_CTL_B_EDGE_LO    14
`define CC_CTL_B_MODE_HI    13
`define CC_CTL_B_MODE_LO    12
`define CC_CTL_B_INVERT     9
`define CC_CTL_B_FUNC       8
`define CC_CTL_A_EDGE_HI    7
`define CC_CTL_A_EDGE_LO    6
`define CC_CTL_A_MODE_HI    5
`define CC_CTL_A_MODE_LO    4
`define CC_CTL_A_INVERT     1
`define CC_CTL_A_FUNC       0
`define CC_CTL_MASK         16'hf3f3

`define CC_IRQ_MATCH_A      0
`define CC_IRQ_MATCH_B      1
`define CC_IRQ_SNAP_A       2
`define CC_IRQ_SNAP_B       3
`define CC_IRQ_LOST_A       4
`define CC_IRQ_LOST_B       5
`define CC_IRQ_W            6

`define CC_EDGE_NONE        2'h0
`define CC_EDGE_RISE        2'h1
`define CC_EDGE_FALL        2'h2
`define CC_EDGE_BOTH        2'h3

`define CC_WAVE_OFF         2'h0
`define CC_WAVE_SET_CLR     2'h1
`define CC_WAVE_TOG_A       2'h2
`define CC_WAVE_TOG_B       2'h3

`define CC_RESET_VALUE      16'h0000

`endif

/* sim/capture_compare_unit_chk.sv */
// port-level assertions for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit_chk #(
	parameter WIDTH = 16
) (
	input wire logic             CLK,
	input wire logic             RESET,
	input wire logic [15:0]      ADDR,
	input wire logic [15:0]      WDATA,
	input wire logic             WRITE,
	input wire logic             READ,
	input wire logic [15:0]      RDATA,
	input wire logic [WIDTH-1:0] COUNT,
	input wire logic             CAPTURE_A_PIN,
	input wire logic             CAPTURE_B_PIN,
	input wire logic             WAVE_A,
	input wire logic             WAVE_B,
	input wire logic             IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_rd(a);
		READ && ADDR == a;
	endsequence
	// enables cleared, then one cycle with no write so no enable is set again
	sequence s_mask_off;
		WRITE && ADDR == 16'h542a && WDATA[5:0] == 6'h00 ##1 !WRITE;
	endsequence
	////////////////////////////////////////////////////////////////
	AST_RD_IDLE: assert property (!READ |=> RDATA == 16'h0000)
		else $error("read data not zero outside read");
	AST_RSV_CTL: assert property (s_rd(16'h5424) |=> (RDATA & 16'h0c0c) == 16'h0)
		else $error("control reserved bits read nonzero");
	AST_RSV_IEN: assert property (s_rd(16'h542a) |=> RDATA[15:6] == 10'h0)
		else $error("enable reserved bits read nonzero");
	AST_RSV_FLG: assert property (s_rd(16'h542c) |=> RDATA[15:6] == 10'h0)
		else $error("flag reserved bits read nonzero");
	AST_UNMAPPED: assert property (READ && (ADDR[0] || ADDR < 16'h5424 || ADDR > 16'h542c)
		|=> RDATA == 16'h0000) else $error("unmapped read nonzero");
	AST_MASKED: assert property (s_mask_off |=> !IRQ)
		else $error("request with all enables off");
	AST_RST_OUT: assert property (disable iff (1'b0) RESET |=> !IRQ && !WAVE_A && !WAVE_B)
		else $error("outputs not low after reset");
	AST_RST_RD: assert property (disable iff (1'b0) RESET |=> RDATA == 16'h0000)
		else $error("read data not zero after reset");
endmodule // capture_compare_unit_chk
bind capture_compare_unit capture_compare_unit_chk #(.WIDTH(WIDTH)) u_chk (.CLK(CLK),
	.RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
	.COUNT(COUNT), .CAPTURE_A_PIN(CAPTURE_A_PIN), .CAPTURE_B_PIN(CAPTURE_B_PIN),
	.WAVE_A(WAVE_A), .WAVE_B(WAVE_B), .IRQ(IRQ));
`default_nettype wire

/* sim/test_timer_capture_compare_unit.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module test_timer_capture_compare_unit;
	logic        clk, reset, write, read;
	logic [15:0] addr, wdata, count, rv, va, vb, c1, c2, m;
	logic [1:0]  pin;
	wire  [15:0] rdata;
	wire         wave_a, wave_b, irq;
	logic [15:0] ed [0:1];
	integer      seed, n_fail, cmp_count, ch, e, n;
	capture_compare_unit #(.WIDTH(16)) u_capture_compare_unit (.CLK(clk), .RESET(reset),
		.ADDR(addr), .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata), .COUNT(count),
		.CAPTURE_A_PIN(pin[0]), .CAPTURE_B_PIN(pin[1]), .WAVE_A(wave_a), .WAVE_B(wave_b),
		.IRQ(irq));
	////////////////////////////////////////////////////////////////
	task chk(input [15:0] got, input [15:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge clk);
		write <= 1'b0;
	endtask
	task rd(input [15:0] a);
		@(posedge clk);
		addr <= a;
		read <= 1'b1;
		@(posedge clk);
		read <= 1'b0;
		#1 rv = rdata;
	endtask
	// count held long enough for the pin synchroniser to settle
	task step(input [15:0] v, input p);
		@(posedge clk);
		count <= v;
		pin[ch] <= p;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail = n_fail + 1;
		stop_test;
	end
	initial begin
		seed = 95089;
		n_fail = 0;
		cmp_count = 0;
		{write, read, addr, wdata, count, pin, ch} = 0;
		reset = 1'b1;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (n = 0; n < 6; n = n + 1) begin
			rd(16'h5424 + 16'(2 * n));
			chk(rv, 16'h0000);
		end
		for (n = 0; n < 5; n = n + 1) begin
			va = 16'($random(seed));
			m = n == 0 ? 16'hf3f3 : n == 3 ? 16'h003f : n == 4 ? 16'h0 : 16'hffff;
			wr(16'h5424 + 16'(2 * n), va);
			rd(16'h5424 + 16'(2 * n));
			chk(rv, va & m);
		end
		// nonzero, so the first step away from count 0 is a real move
		va = 16'($random(seed)) | 16'h0100;
		vb = va ^ 16'h8001;
		wr(16'h5424, 16'h1020);
		wr(16'h5426, va);
		wr(16'h5428, vb);
		wr(16'h542c, 16'h003f);
		wr(16'h542a, 16'h003f);
		step(va, 1'b0);
		chk({14'h0, wave_b, wave_a}, 16'h0003);
		step(vb, 1'b0);
		chk({14'h0, wave_b, wave_a}, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		rd(16'h542c);
		chk(rv, 16'h0003);
		wr(16'h542c, 16'h0001);
		rd(16'h542c);
		chk(rv, 16'h0002);
		wr(16'h542a, 16'h0000);
		rd(16'h542c);
		chk({15'h0, irq}, 16'h0000);
		wr(16'h5424, 16'h1222);
		rd(16'h5424);
		chk({14'h0, wave_b, wave_a}, 16'h0002);
		wr(16'h5424, 16'h2030);
		step(va, 1'b0);
		chk({14'h0, wave_b, wave_a}, 16'h0003);
		step(vb, 1'b0);
		chk({14'h0, wave_b, wave_a}, 16'h0002);
		ed[0] = va;
		ed[1] = vb;
		for (ch = 0; ch < 2; ch = ch + 1) begin
			for (e = 0; e < 4; e = e + 1) begin
				wr(16'h5424, ch ? {e[1:0], 5'h00, 1'b1, 8'h00} : {8'h00, e[1:0], 5'h00, 1'b1});
				wr(16'h542c, 16'h003f);
				c1 = 16'($random(seed));
				c2 = 16'($random(seed));
				step(c1, 1'b1);
				step(c2, 1'b0);
				if (e[1])
					ed[ch] = c2;
				else if (e[0])
					ed[ch] = c1;
				rd(ch ? 16'h5428 : 16'h5426);
				chk(rv, ed[ch]);
				m = ch ? 16'h0028 : 16'h0014;
				rd(16'h542c);
				chk(rv & m, m & {10'h0, {2{e == 3}}, {2{e != 0}}, 2'b00});
			end
		end
		chk({14'h0, wave_b, wave_a}, 16'h0000);
		stop_test;
	end
endmodule // test_timer_capture_compare_unit
`default_nettype wire
